/* src/sit_dev.sv */
/*
  Target end of the sensor port: address decode, command capture, read data
  shifting, coefficient transfer with clock stretch during internal write.
  Assumes link wires come from another domain and are sampled on core_clk.
*/
`timescale 1ns/1ns
// Operation
// - first byte is address then direction
// - answer only target address 0x67
// - command write is address then one code
// - read is command write, repeated start, read
// - read data goes out most significant first
// - coefficient write sends e4 then 6f
// - exactly four coefficient bytes follow
// - last coefficient byte gets NACK, normal completion
// - internal write busy at most 15 ms
// - hold SCL low while internal write busy
// - release SCL when internal write finishes
// - coefficient write only while device idle
// - shutdown restores default coefficient
// - coefficient bytes sent most significant first
module sit_dev #(
  parameter int unsigned BUSY_CYCLES = sit_pkg::SIT_BUSY_CYCLES,
  parameter int RD_BYTES = sit_pkg::SIT_RD_BYTES,
  parameter logic [255:0] CMD_ALLOWED = {256{1'b1}},
  parameter logic [31:0] COEF_DEFAULT = sit_pkg::SIT_COEF_DEFAULT
)(
  input wire logic core_clk,
  input wire logic rst_n,
  sit_if.device link,
  input wire logic dev_idle,
  input wire logic shutdown,
  input wire logic [RD_BYTES*8-1:0] rd_data,
  output logic [7:0] cmd_code,
  output logic cmd_valid,
  output logic [31:0] coef_value,
  output logic coef_valid,
  output logic stretching
);
  localparam int RD_W = RD_BYTES * 8;
  typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_RACK, D_BUSY} sit_dstate_e;

  sit_dstate_e state_reg;
  logic scl_m_reg;
  logic scl_s_reg;
  logic scl_q_reg;
  logic sda_m_reg;
  logic sda_s_reg;
  logic sda_q_reg;
  logic [7:0] shreg_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_idx_reg;
  logic rw_reg;
  logic ack_reg;
  logic ack_on_reg;
  logic coef_mode_reg;
  logic [31:0] coef_acc_reg;
  logic [31:0] coef_reg;
  logic coef_valid_reg;
  logic [RD_W-1:0] rd_sh_reg;
  logic [7:0] cmd_code_reg;
  logic cmd_valid_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic [31:0] busy_cnt_reg;
  logic rise;
  logic fall;
  logic start_ev;
  logic stop_ev;
  logic busy_done;
  logic ack_ok;
  logic [7:0] rx_byte;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_q_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end
    else
    begin
      scl_m_reg <= link.scl;
      scl_s_reg <= scl_m_reg;
      scl_q_reg <= scl_s_reg;
      sda_m_reg <= link.sda;
      sda_s_reg <= sda_m_reg;
      sda_q_reg <= sda_s_reg;
    end
  end

  assign rise = scl_s_reg & ~scl_q_reg;
  assign fall = ~scl_s_reg & scl_q_reg;
  assign start_ev = scl_s_reg & scl_q_reg & sda_q_reg & ~sda_s_reg;
  assign stop_ev = scl_s_reg & scl_q_reg & ~sda_q_reg & sda_s_reg;
  assign rx_byte = {shreg_reg[6:0], sda_s_reg};
  assign busy_done = (state_reg == D_BUSY) && (busy_cnt_reg == BUSY_CYCLES - 1);

  always_comb
  begin
    ack_ok = 1'b0;
    case (byte_idx_reg)
      3'h0: ack_ok = rx_byte[7:1] == sit_pkg::SIT_TARGET_ADDR;
      // coefficient command refused unless the measurement side is idle
      3'h1: ack_ok = (rx_byte == sit_pkg::SIT_CMD_COEF) ? dev_idle : CMD_ALLOWED[rx_byte];
      3'h2: ack_ok = coef_mode_reg & (rx_byte == sit_pkg::SIT_COEF_MEM_ADDR);
      default: ack_ok = coef_mode_reg & (byte_idx_reg != sit_pkg::SIT_COEF_LAST_IDX);
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= D_IDLE;
      shreg_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      byte_idx_reg <= 3'h0;
      rw_reg <= 1'b0;
      ack_reg <= 1'b0;
      ack_on_reg <= 1'b0;
      coef_mode_reg <= 1'b0;
      coef_acc_reg <= 32'h0000_0000;
      rd_sh_reg <= '0;
      cmd_code_reg <= 8'h00;
      cmd_valid_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      cmd_valid_reg <= 1'b0;
      if (start_ev)
      begin
        state_reg <= D_RX;
        bit_cnt_reg <= 3'h0;
        byte_idx_reg <= 3'h0;
        coef_mode_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
      end
      else if (stop_ev)
      begin
        state_reg <= D_IDLE;
        sda_oe_reg <= 1'b0;
      end
      else
      begin
        case (state_reg)
          D_RX:
            if (rise)
            begin
              shreg_reg <= rx_byte;
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == 3'h7)
              begin
                ack_reg <= ack_ok;
                ack_on_reg <= 1'b0;
                state_reg <= D_ACK;
                if (byte_idx_reg == 3'h0)
                  rw_reg <= rx_byte[0];
                if (byte_idx_reg == 3'h1 && ack_ok)
                begin
                  coef_mode_reg <= rx_byte == sit_pkg::SIT_CMD_COEF;
                  if (rx_byte != sit_pkg::SIT_CMD_COEF)
                  begin
                    cmd_code_reg <= rx_byte;
                    cmd_valid_reg <= 1'b1;
                  end
                end
                if (coef_mode_reg && byte_idx_reg >= 3'h3)
                  coef_acc_reg <= {coef_acc_reg[23:0], rx_byte};
              end
            end
          D_ACK:
            if (fall)
            begin
              if (!ack_on_reg)
              begin
                sda_oe_reg <= ack_reg;
                ack_on_reg <= 1'b1;
              end
              else
              begin
                ack_on_reg <= 1'b0;
                sda_oe_reg <= 1'b0;
                byte_idx_reg <= byte_idx_reg + 3'h1;
                if (coef_mode_reg && byte_idx_reg == sit_pkg::SIT_COEF_LAST_IDX)
                begin
                  // pulled right after the ninth clock so the host cannot move on
                  state_reg <= D_BUSY;
                  scl_oe_reg <= 1'b1;
                end
                else if (!ack_reg)
                  state_reg <= D_IDLE;
                else if (rw_reg)
                begin
                  state_reg <= D_TX;
                  bit_cnt_reg <= 3'h0;
                  shreg_reg <= rd_data[RD_W-1 -: 8];
                  rd_sh_reg <= rd_data << 8;
                  sda_oe_reg <= ~rd_data[RD_W-1];
                end
                else
                  state_reg <= D_RX;
              end
            end
          D_TX:
            if (fall)
            begin
              if (bit_cnt_reg == 3'h7)
              begin
                sda_oe_reg <= 1'b0;
                state_reg <= D_RACK;
              end
              else
              begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                shreg_reg <= {shreg_reg[6:0], 1'b0};
                sda_oe_reg <= ~shreg_reg[6];
              end
            end
          D_RACK:
            if (rise)
              ack_reg <= ~sda_s_reg;
            else if (fall)
            begin
              if (ack_reg)
              begin
                // bytes past the end of rd_data read as zero
                state_reg <= D_TX;
                bit_cnt_reg <= 3'h0;
                shreg_reg <= rd_sh_reg[RD_W-1 -: 8];
                rd_sh_reg <= rd_sh_reg << 8;
                sda_oe_reg <= ~rd_sh_reg[RD_W-1];
              end
              else
                state_reg <= D_IDLE;
            end
          D_BUSY:
            if (busy_done)
            begin
              scl_oe_reg <= 1'b0;
              state_reg <= D_IDLE;
            end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_cnt_reg <= 32'h0000_0000;
    else if (state_reg != D_BUSY)
      busy_cnt_reg <= 32'h0000_0000;
    else
      busy_cnt_reg <= busy_cnt_reg + 32'h1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      coef_reg <= COEF_DEFAULT;
      coef_valid_reg <= 1'b0;
    end
    else
    begin
      coef_valid_reg <= busy_done & ~shutdown;
      if (shutdown)
        coef_reg <= COEF_DEFAULT;
      else if (busy_done)
        coef_reg <= coef_acc_reg;
    end
  end

  assign link.dev_scl_o = 1'b0;
  assign link.dev_sda_o = 1'b0;
  assign link.dev_scl_oe = scl_oe_reg;
  assign link.dev_sda_oe = sda_oe_reg;
  assign cmd_code = cmd_code_reg;
  assign cmd_valid = cmd_valid_reg;
  assign coef_value = coef_reg;
  assign coef_valid = coef_valid_reg;
  assign stretching = scl_oe_reg;
endmodule

/* src/sit_pkg.sv */
/*
  Shared constants and types for the sensor target port link: target
  address, command codes, coefficient transfer shape, busy time, host bit
  timing. Assumes a 100 MHz core clock at both ends.
*/
package sit_pkg;
  localparam logic [6:0] SIT_TARGET_ADDR = 7'h67;
  localparam logic [7:0] SIT_ADDR_WR = {SIT_TARGET_ADDR, 1'b0};
  localparam logic [7:0] SIT_ADDR_RD = {SIT_TARGET_ADDR, 1'b1};
  localparam logic [7:0] SIT_CMD_COEF = 8'he4;
  localparam logic [7:0] SIT_COEF_MEM_ADDR = 8'h6f;
  localparam int SIT_COEF_BYTES = 4;
  // byte index of the last coefficient byte: address, command, memory address, then data
  localparam logic [2:0] SIT_COEF_LAST_IDX = 3'(2 + SIT_COEF_BYTES);
  localparam logic [31:0] SIT_COEF_DEFAULT = 32'h0000_0000;
  localparam int unsigned SIT_CORE_CLK_HZ = 100_000_000;
  localparam int unsigned SIT_BUSY_TIME_MS = 15;
  localparam int unsigned SIT_BUSY_CYCLES = SIT_BUSY_TIME_MS * (SIT_CORE_CLK_HZ / 1000);
  localparam int SIT_QUARTER_CYCLES = 3;
  localparam int SIT_RD_BYTES = 3;
  typedef enum logic [1:0] {SIT_K_CMD, SIT_K_READ, SIT_K_COEF} sit_kind_e;
endpackage

/* src/sit_if.sv */
/*
  Two-wire open-drain link between host end and target end.
  Each end gives output value and enable per wire; wire level resolved here.
*/
`timescale 1ns/1ns
interface sit_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // wired-and with pull-up: any enabled low driver wins
  assign scl = ~((host_scl_oe & ~host_scl_o) | (dev_scl_oe & ~dev_scl_o));
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
  modport device (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

/* src/sit_host.sv */
/*
  Controller end of the sensor port: runs command, combined read and
  coefficient transfers. Makes SCL by dividing core_clk; waits out stretch.
  Assumes the link wires are open drain and come from another domain.
*/
`timescale 1ns/1ns
module sit_host #(
  parameter int QUARTER = sit_pkg::SIT_QUARTER_CYCLES
)(
  input wire logic core_clk,
  input wire logic rst_n,
  sit_if.host link,
  input wire logic req_valid,
  input wire sit_pkg::sit_kind_e req_kind,
  input wire logic [7:0] req_cmd,
  input wire logic [31:0] req_coef,
  input wire logic [2:0] req_rd_len,
  output logic req_ready,
  output logic [7:0] rd_byte,
  output logic rd_valid,
  output logic done,
  output logic nack_err
);
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} sit_hstate_e;

  sit_hstate_e state_reg;
  sit_pkg::sit_kind_e kind_reg;
  logic scl_m_reg;
  logic scl_s_reg;
  logic sda_m_reg;
  logic sda_s_reg;
  logic [7:0] qcnt_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_n_reg;
  logic [3:0] step_reg;
  logic [7:0] cmd_reg;
  logic [31:0] coef_sh_reg;
  logic [2:0] len_reg;
  logic [7:0] txb_reg;
  logic [7:0] rxb_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic ready_reg;
  logic [7:0] rd_byte_reg;
  logic rd_valid_reg;
  logic done_reg;
  logic err_reg;
  logic tick;
  logic adv;
  logic is_read;
  logic [3:0] last_step;
  logic nack_ok;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end
    else
    begin
      scl_m_reg <= link.scl;
      scl_s_reg <= scl_m_reg;
      sda_m_reg <= link.sda;
      sda_s_reg <= sda_m_reg;
    end
  end

  assign tick = qcnt_reg == 8'(QUARTER - 1);
  // leaving quarter 2 needs SCL seen high: this is where a stretch holds us
  assign adv = tick & ((q_reg != 2'h2) | scl_s_reg);
  assign is_read = (kind_reg == sit_pkg::SIT_K_READ) && (step_reg >= 4'h3);
  assign last_step = (kind_reg == sit_pkg::SIT_K_COEF) ? 4'(sit_pkg::SIT_COEF_LAST_IDX) :
                     (kind_reg == sit_pkg::SIT_K_READ) ? 4'h2 + {1'b0, len_reg} : 4'h1;
  // the device ends a coefficient write with NACK; that is success
  assign nack_ok = (kind_reg == sit_pkg::SIT_K_COEF) && (step_reg == last_step);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      qcnt_reg <= 8'h00;
    else if (state_reg == H_IDLE || adv)
      qcnt_reg <= 8'h00;
    else if (!tick)
      qcnt_reg <= qcnt_reg + 8'h01;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= H_IDLE;
      kind_reg <= sit_pkg::SIT_K_CMD;
      q_reg <= 2'h0;
      bit_n_reg <= 4'h0;
      step_reg <= 4'h0;
      cmd_reg <= 8'h00;
      coef_sh_reg <= 32'h0000_0000;
      len_reg <= 3'h1;
      txb_reg <= 8'h00;
      rxb_reg <= 8'h00;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      ready_reg <= 1'b1;
      rd_byte_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
    end
    else
    begin
      rd_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      if (state_reg == H_IDLE)
      begin
        if (req_valid && ready_reg)
        begin
          ready_reg <= 1'b0;
          kind_reg <= req_kind;
          cmd_reg <= req_cmd;
          coef_sh_reg <= req_coef;
          len_reg <= (req_rd_len == 3'h0) ? 3'h1 : req_rd_len;
          step_reg <= 4'h0;
          txb_reg <= sit_pkg::SIT_ADDR_WR;
          err_reg <= 1'b0;
          q_reg <= 2'h0;
          state_reg <= H_START;
        end
      end
      else if (adv)
      begin
        q_reg <= q_reg + 2'h1;
        case (state_reg)
          H_START:
            case (q_reg)
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b1;
              2'h3:
              begin
                scl_oe_reg <= 1'b1;
                bit_n_reg <= 4'h0;
                state_reg <= H_BIT;
              end
              default: sda_oe_reg <= 1'b0;
            endcase
          H_BIT:
            case (q_reg)
              2'h0:
                if (bit_n_reg != 4'h8)
                  sda_oe_reg <= ~is_read & ~txb_reg[7];
                else
                  sda_oe_reg <= is_read & (step_reg != last_step);
              2'h1: scl_oe_reg <= 1'b0;
              2'h3:
              begin
                scl_oe_reg <= 1'b1;
                if (bit_n_reg != 4'h8)
                begin
                  rxb_reg <= {rxb_reg[6:0], sda_s_reg};
                  txb_reg <= {txb_reg[6:0], 1'b0};
                  bit_n_reg <= bit_n_reg + 4'h1;
                end
                else
                begin
                  bit_n_reg <= 4'h0;
                  sda_oe_reg <= 1'b0;
                  if (is_read)
                  begin
                    rd_byte_reg <= rxb_reg;
                    rd_valid_reg <= 1'b1;
                  end
                  if (!is_read && (sda_s_reg != nack_ok))
                  begin
                    err_reg <= 1'b1;
                    state_reg <= H_STOP;
                  end
                  else if (step_reg == last_step)
                    state_reg <= H_STOP;
                  else
                  begin
                    step_reg <= step_reg + 4'h1;
                    if (step_reg == 4'h0)
                      txb_reg <= (kind_reg == sit_pkg::SIT_K_COEF) ? sit_pkg::SIT_CMD_COEF : cmd_reg;
                    else if (step_reg == 4'h1 && kind_reg == sit_pkg::SIT_K_READ)
                    begin
                      txb_reg <= sit_pkg::SIT_ADDR_RD;
                      state_reg <= H_START;
                    end
                    else if (step_reg == 4'h1)
                      txb_reg <= sit_pkg::SIT_COEF_MEM_ADDR;
                    else
                    begin
                      txb_reg <= coef_sh_reg[31:24];
                      coef_sh_reg <= {coef_sh_reg[23:0], 8'h00};
                    end
                  end
                end
              end
              default: ;
            endcase
          H_STOP:
            case (q_reg)
              2'h0: sda_oe_reg <= 1'b1;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b0;
              default:
              begin
                state_reg <= H_IDLE;
                ready_reg <= 1'b1;
                done_reg <= 1'b1;
              end
            endcase
          default: state_reg <= H_IDLE;
        endcase
      end
    end
  end

  assign link.host_scl_o = 1'b0;
  assign link.host_sda_o = 1'b0;
  assign link.host_scl_oe = scl_oe_reg;
  assign link.host_sda_oe = sda_oe_reg;
  assign req_ready = ready_reg;
  assign rd_byte = rd_byte_reg;
  assign rd_valid = rd_valid_reg;
  assign done = done_reg;
  assign nack_err = err_reg;
endmodule

/* bench/sit_link_properties.sv */
/*
  Checker for the two-wire link between host end and target end.
  Assumes it sees the interface wires plainly, clocked by core_clk.
*/
`timescale 1ns/1ns
module sit_link_checker #(
  parameter int unsigned BUSY_CYCLES = 200
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic scl_q;
  logic sda_q;
  logic first_byte;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  int unsigned stretch_cnt;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // bit position within the current byte, reset by every start
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt <= 4'h0;
      first_byte <= 1'b0;
      shreg <= 8'h00;
    end
    else if (sda_q && !sda && scl)
    begin
      bit_cnt <= 4'h0;
      first_byte <= 1'b1;
    end
    else if (!scl_q && scl)
    begin
      if (bit_cnt == 4'h8)
      begin
        bit_cnt <= 4'h0;
        first_byte <= 1'b0;
      end
      else
      begin
        bit_cnt <= bit_cnt + 4'h1;
        shreg <= {shreg[6:0], sda};
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      stretch_cnt <= 0;
    else if (dev_scl_oe)
      stretch_cnt <= stretch_cnt + 1;
    else
      stretch_cnt <= 0;
  end
  // target only listens while the address and direction bits go by
  property p_addr_listen;
    (first_byte && bit_cnt != 4'h8) |-> !dev_sda_oe;
  endproperty
  a_addr_listen: assert property (p_addr_listen) else $error("target pulled data during address byte");
  property p_addr_ack;
    (first_byte && bit_cnt == 4'h8 && !scl_q && scl) |-> (sda == (shreg[7:1] != sit_pkg::SIT_TARGET_ADDR));
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address byte answered wrongly");
  property p_sda_steady_scl_high;
    (scl && $past(scl)) |-> $stable(dev_sda_oe);
  endproperty
  a_sda_steady_scl_high: assert property (p_sda_steady_scl_high) else $error("target moved data with clock high");
  property p_stretch_after_low;
    $rose(dev_scl_oe) |-> $past(host_scl_oe, 1);
  endproperty
  a_stretch_after_low: assert property (p_stretch_after_low) else $error("stretch began with clock high");
  property p_stretch_min;
    $fell(dev_scl_oe) |-> stretch_cnt >= BUSY_CYCLES - 2;
  endproperty
  a_stretch_min: assert property (p_stretch_min) else $error("stretch released early");
  property p_stretch_max;
    stretch_cnt <= BUSY_CYCLES + 4;
  endproperty
  a_stretch_max: assert property (p_stretch_max) else $error("stretch held too long");
  property p_host_waits;
    (dev_scl_oe && $past(dev_scl_oe)) |-> $stable(host_sda_oe) && !scl;
  endproperty
  a_host_waits: assert property (p_host_waits) else $error("host moved during stretch");
  property p_quiet_after_reset;
    $rose(rst_n) |-> (!dev_scl_oe && !dev_sda_oe && !host_scl_oe)[*2];
  endproperty
  a_quiet_after_reset: assert property (p_quiet_after_reset) else $error("wire pulled right after reset");
  c_addr_ack: cover property (first_byte && bit_cnt == 4'h8 && !scl_q && scl && !sda);
  c_stretch_done: cover property ($fell(dev_scl_oe));
  c_read_drive: cover property (!first_byte && dev_sda_oe && scl);
endmodule

/* bench/sensor_i2c_target_port_tb.sv */
/*
  Testbench joining host end and target end through the link interface.
  Assumes 100 MHz core clock, short busy count, no bench-made link clock.
*/
`timescale 1ns/1ns
module sensor_i2c_target_port_tb;
  localparam int unsigned BUSY = 200;
  localparam logic [31:0] COEF_DEF = 32'h0f1e_2d3c;
  localparam logic [255:0] ALLOWED = ~(256'h1 << 8'h5a);
  logic core_clk, rst_n, req_valid, req_ready, rd_valid, done, nack_err;
  logic dev_idle, shutdown, cmd_valid, coef_valid, stretching;
  sit_pkg::sit_kind_e req_kind;
  logic [7:0] req_cmd, rd_byte, cmd_code, last_cmd;
  logic [31:0] req_coef, coef_value;
  logic [2:0] req_rd_len;
  logic [23:0] rd_data;
  logic [7:0] cmds [4] = '{8'hc4, 8'h00, 8'hff, 8'h5a};
  logic [2:0] lens [3] = '{3'h0, 3'h3, 3'h5};
  logic [7:0] got_q [$];
  int miscompares, checks, coef_pulses, nb;
  int unsigned stretch_len;
  sit_if link();
  sit_host #(.QUARTER(3)) i_sit_host (.core_clk(core_clk), .rst_n(rst_n), .link(link.host),
    .req_valid(req_valid), .req_kind(req_kind), .req_cmd(req_cmd), .req_coef(req_coef),
    .req_rd_len(req_rd_len), .req_ready(req_ready), .rd_byte(rd_byte), .rd_valid(rd_valid),
    .done(done), .nack_err(nack_err));
  sit_dev #(.BUSY_CYCLES(BUSY), .RD_BYTES(3), .CMD_ALLOWED(ALLOWED), .COEF_DEFAULT(COEF_DEF)) i_sit_dev (
    .core_clk(core_clk), .rst_n(rst_n), .link(link.device), .dev_idle(dev_idle), .shutdown(shutdown),
    .rd_data(rd_data), .cmd_code(cmd_code), .cmd_valid(cmd_valid), .coef_value(coef_value),
    .coef_valid(coef_valid), .stretching(stretching));
  sit_link_checker #(.BUSY_CYCLES(BUSY)) i_sit_link_checker (.core_clk(core_clk), .rst_n(rst_n),
    .host_scl_o(link.host_scl_o), .host_scl_oe(link.host_scl_oe), .host_sda_o(link.host_sda_o),
    .host_sda_oe(link.host_sda_oe), .dev_scl_o(link.dev_scl_o), .dev_scl_oe(link.dev_scl_oe),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // target user-side pulses, read at the edge before they drop
  always @(posedge core_clk)
  begin
    if (cmd_valid === 1'b1)
      last_cmd <= cmd_code;
    if (coef_valid === 1'b1)
      coef_pulses <= coef_pulses + 1;
    if (stretching === 1'b1)
      stretch_len <= stretch_len + 1;
  end
  task automatic tally_and_finish;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // entered just after an edge; presents one request, collects read bytes until done
  task automatic xfer(input sit_pkg::sit_kind_e kind, input logic [7:0] cmd, input logic [31:0] coef,
    input logic [2:0] len);
    int n;
    got_q.delete();
    n = 0;
    while (req_ready !== 1'b1 && n < 100)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (req_ready !== 1'b1)
    begin
      chk(32'h0, 32'h1);
      tally_and_finish();
    end
    req_valid = 1'b1;
    req_kind = kind;
    req_cmd = cmd;
    req_coef = coef;
    req_rd_len = len;
    @(posedge core_clk);
    #1 req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1)
    begin
      if (n == 20000)
      begin
        chk(32'h0, 32'h1);
        tally_and_finish();
      end
      @(posedge core_clk);
      #1;
      n++;
      if (rd_valid === 1'b1)
        got_q.push_back(rd_byte);
    end
  endtask
  initial
  begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_kind = sit_pkg::SIT_K_CMD;
    req_cmd = 8'h00;
    req_coef = 32'h0;
    req_rd_len = 3'h0;
    dev_idle = 1'b1;
    shutdown = 1'b0;
    rd_data = 24'hc1_3e_70;
    last_cmd = 8'h00;
    coef_pulses = 0;
    stretch_len = 0;
    repeat (8) @(posedge core_clk);
    #1 rst_n = 1'b1;
    chk(coef_value, COEF_DEF);
    chk(32'(req_ready), 32'h1);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      xfer(sit_pkg::SIT_K_CMD, cmds[i], 32'h0, 3'h0);
      chk(32'(nack_err), 32'(cmds[i] == 8'h5a));
      chk(last_cmd, (i == 3) ? 8'hff : cmds[i]);
    end
    $display("test command done");
    for (int j = 0; j < 3; j++)
    begin
      xfer(sit_pkg::SIT_K_READ, 8'hc4, 32'h0, lens[j]);
      nb = (lens[j] == 3'h0) ? 1 : 32'(lens[j]);
      chk(got_q.size(), nb);
      chk(32'(nack_err), 32'h0);
      for (int k = 0; k < nb && k < got_q.size(); k++)
        chk(got_q[k], (k < 3) ? rd_data[23 - 8 * k -: 8] : 8'h00);
    end
    $display("test read done");
    xfer(sit_pkg::SIT_K_COEF, sit_pkg::SIT_CMD_COEF, 32'h8765_4321, 3'h0);
    chk(32'(nack_err), 32'h0);
    chk(coef_value, 32'h8765_4321);
    chk(coef_pulses, 1);
    chk(32'(stretch_len >= BUSY && stretch_len <= BUSY + 4), 32'h1);
    $display("test coefficient done");
    dev_idle = 1'b0;
    xfer(sit_pkg::SIT_K_COEF, sit_pkg::SIT_CMD_COEF, 32'h1122_3344, 3'h0);
    chk(32'(nack_err), 32'h1);
    chk(coef_value, 32'h8765_4321);
    dev_idle = 1'b1;
    $display("test busy refusal done");
    shutdown = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 shutdown = 1'b0;
    @(posedge core_clk);
    #1;
    chk(coef_value, COEF_DEF);
    $display("test shutdown done");
    tally_and_finish();
  end
endmodule
